// >>> tx_shaper_pkg.sv
// Constants, register map and pulse tables for the transmit shaper
package tx_shaper_pkg;

   // Clock and timing
   localparam int HCLK_NS     = 40;
   localparam int LOSS_NS     = 2560;
   localparam int LOSS_CYC    = (LOSS_NS + HCLK_NS - 1) / HCLK_NS;
   localparam int T1_BIT_NS   = 648;
   localparam int E1_BIT_NS   = 488;
   localparam int T1_BIT_CYC  = T1_BIT_NS / HCLK_NS;
   localparam int E1_BIT_CYC  = E1_BIT_NS / HCLK_NS;
   localparam int SEG_COUNT   = 8;
   localparam int T1_SEG_CYC  = T1_BIT_CYC / SEG_COUNT;
   localparam int E1_SEG_CYC  = E1_BIT_CYC / SEG_COUNT;
   localparam int DMO_LIMIT   = 128;

   // Quasi-random generator lengths and feedback taps
   localparam int T1_LEN      = 20;
   localparam int T1_TAP      = 17;
   localparam int E1_LEN      = 15;
   localparam int E1_TAP      = 14;
   localparam logic [19:0] LFSR_RST = 20'hFFFFF;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [2:0] SEG_BLK  = 3'h1;

   // Control field positions
   localparam int CTRL_E1     = 0;
   localparam int CTRL_QRSS   = 1;
   localparam int CTRL_FILL   = 2;
   localparam int CTRL_TRI    = 3;
   localparam int CTRL_ARB    = 4;
   localparam int CTRL_DUAL   = 5;
   localparam int CTRL_BOS    = 8;

   // Status field positions
   localparam int STAT_DMO_EV   = 0;
   localparam int STAT_LOSS_EV  = 1;
   localparam int STAT_DMO_LIVE = 8;
   localparam int STAT_LOSS_LIV = 9;

   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [1:0]  MASK_RST = 2'h0;
   localparam logic [6:0]  SEG_RST  = 7'h00;

   // Preset build-out codes
   localparam logic [4:0] BOS_FIRST = 5'h08;
   localparam logic [4:0] BOS_LAST  = 5'h0C;

   // Preset segment words, one row per cable range, positive pulse
   localparam logic [6:0] PRESET [0:4][0:7] = '{
      '{7'h10, 7'h24, 7'h20, 7'h1E, 7'h1C, 7'h42, 7'h42, 7'h01},
      '{7'h12, 7'h28, 7'h22, 7'h20, 7'h1E, 7'h44, 7'h43, 7'h01},
      '{7'h14, 7'h2C, 7'h24, 7'h22, 7'h20, 7'h46, 7'h44, 7'h02},
      '{7'h16, 7'h30, 7'h26, 7'h24, 7'h22, 7'h48, 7'h45, 7'h02},
      '{7'h18, 7'h34, 7'h28, 7'h26, 7'h24, 7'h4A, 7'h46, 7'h03}
   };

endpackage

// >>> tx_shaper.sv
// Transmit shaper: test pattern, clock-loss fill, pulse DAC codes, monitor
//
// Functional notes
// - Quasi-random pattern, 2^20-1 T1, 2^15-1 E1.
// - Lost transmit clock sends fixed fill pattern.
// - Fill is zeros; select bit gives ones.
// - DAC codes: sign bit plus 6-bit magnitude.
// - Build-out codes 08h..0Ch pick preset shapes.
// - Eight segments per pulse, preset fixed values.
// - Arbitrary mode uses eight programmed segment words.
// - Sign bit zero positive, one negative.
// - All-ones code gives maximum, rail-clamped amplitude.
// - Segment words reset to zero.
// - Flag after 129 pulseless bit periods until pulse.
// - Flag change with enable drives interrupt low.
// - Status read releases interrupt, clears latched bits.
// - Tri-state bit drops line_out_oe; tip and ring keep driving.
// - Diagnostic pattern overrides transmit data inputs.
// - Diagnostic pattern forces single-rail operation.
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps

module tx_shaper (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Framer side
   input  wire logic        line_tx_clock,
   input  wire logic        tx_data_positive,
   input  wire logic        tx_data_negative,
   // Line driver side
   output logic [6:0]       dac_code,
   output logic             dac_at_rail,
   output logic             line_out_tip,
   output logic             line_out_ring,
   output logic             line_out_oe,
   // Monitor and interrupt
   output logic             driver_monitor_flag,
   output logic             irq_n
);

   typedef struct packed {
      logic              line_tx_clock_s1;
      logic              line_tx_clock_s2;
      logic              line_tx_clock_d;
      logic              pos_s1;
      logic              pos_s2;
      logic              neg_s1;
      logic              neg_s2;
      logic [7:0]        loss_cnt;
      logic              clk_lost;
      logic [4:0]        bit_div;
      logic              seg_act;
      logic [2:0]        seg_idx;
      logic [1:0]        seg_div;
      logic              pol;
      logic              ami_last;
      logic [19:0]       lfsr;
      logic [7:0]        dmo_cnt;
      logic              dmo_flag;
      logic [15:0]       ctrl;
      logic [7:0][6:0]   seg_word;
      logic [1:0]        status;
      logic [1:0]        mask;
      logic              ph_valid;
      logic              ph_write;
      logic [7:0]        ph_addr;
      logic              rdy;
      logic              resp;
      logic [31:0]       rdata;
      logic [6:0]        dac;
      logic              at_rail;
      logic              tip;
      logic              ring;
      logic              oe;
      logic              irq_n;
   } state_s;

   state_s r_r;
   state_s r_nxt;

   logic       line_tx_clock_rise;
   logic       line_tx_clock_edge;
   logic       bit_go;
   logic       mark;
   logic       mark_pol;
   logic       diag;
   logic       fb;
   logic [1:0] seg_len;
   logic [6:0] word;
   logic [4:0] row;
   logic [1:0] ev;
   logic [1:0] clr;
   logic       addr_ok;
   logic [31:0] rd;
   logic [19:0] lfsr_n;

   // Whole block next state
   always_comb begin
      r_nxt     = r_r;
      line_tx_clock_rise = 1'b0;
      line_tx_clock_edge = 1'b0;
      bit_go    = 1'b0;
      mark      = 1'b0;
      mark_pol  = 1'b0;
      diag      = 1'b0;
      fb        = 1'b0;
      seg_len   = 2'h0;
      word      = 7'h00;
      row       = 5'h00;
      ev        = 2'h0;
      clr       = 2'h0;
      addr_ok   = 1'b0;
      rd        = 32'h0000_0000;
      lfsr_n    = r_r.lfsr;

      // Two-stage synchronisers; data and clock share the same delay
      r_nxt.line_tx_clock_s1 = line_tx_clock;
      r_nxt.line_tx_clock_s2 = r_r.line_tx_clock_s1;
      r_nxt.line_tx_clock_d  = r_r.line_tx_clock_s2;
      r_nxt.pos_s1  = tx_data_positive;
      r_nxt.pos_s2  = r_r.pos_s1;
      r_nxt.neg_s1  = tx_data_negative;
      r_nxt.neg_s2  = r_r.neg_s1;
      line_tx_clock_rise = r_r.line_tx_clock_s2 & ~r_r.line_tx_clock_d;
      line_tx_clock_edge = r_r.line_tx_clock_s2 ^ r_r.line_tx_clock_d;

      // Clock loss: no edge in either direction covers stuck high and low
      if (line_tx_clock_edge) begin
         r_nxt.loss_cnt = 8'h00;
         r_nxt.clk_lost = 1'b0;
      end else if (r_r.loss_cnt != 8'(tx_shaper_pkg::LOSS_CYC)) begin
         r_nxt.loss_cnt = r_r.loss_cnt + 8'h01;
      end else begin
         r_nxt.clk_lost = 1'b1;
      end

      // Local bit timer stands in for the missing line clock
      if (r_r.clk_lost) begin
         if (r_r.bit_div == 5'h00) begin
            r_nxt.bit_div = r_r.ctrl[tx_shaper_pkg::CTRL_E1] ?
               5'(tx_shaper_pkg::E1_BIT_CYC - 1) : 5'(tx_shaper_pkg::T1_BIT_CYC - 1);
         end else begin
            r_nxt.bit_div = r_r.bit_div - 5'h01;
         end
      end else begin
         r_nxt.bit_div = 5'h00;
      end
      bit_go = r_r.clk_lost ? (r_r.bit_div == 5'h00) : line_tx_clock_rise;

      // Segment pacing: eight segments per pulse, two cycles each for T1, one for E1
      seg_len = r_r.ctrl[tx_shaper_pkg::CTRL_E1] ?
         2'(tx_shaper_pkg::E1_SEG_CYC - 1) : 2'(tx_shaper_pkg::T1_SEG_CYC - 1);
      if (r_r.seg_act) begin
         if (r_r.seg_div == 2'h0) begin
            r_nxt.seg_div = seg_len;
            if (r_r.seg_idx == 3'h7) begin
               r_nxt.seg_act = 1'b0;
            end else begin
               r_nxt.seg_idx = r_r.seg_idx + 3'h1;
            end
         end else begin
            r_nxt.seg_div = r_r.seg_div - 2'h1;
         end
      end

      // Bit source; diagnostic modes beat the data inputs
      diag = r_r.clk_lost | r_r.ctrl[tx_shaper_pkg::CTRL_QRSS];
      fb = r_r.ctrl[tx_shaper_pkg::CTRL_E1] ?
         (r_r.lfsr[tx_shaper_pkg::E1_LEN-1] ^ r_r.lfsr[tx_shaper_pkg::E1_TAP-1]) :
         (r_r.lfsr[tx_shaper_pkg::T1_LEN-1] ^ r_r.lfsr[tx_shaper_pkg::T1_TAP-1]);
      if (r_r.clk_lost) begin
         mark = r_r.ctrl[tx_shaper_pkg::CTRL_FILL];
      end else if (r_r.ctrl[tx_shaper_pkg::CTRL_QRSS]) begin
         mark = r_r.ctrl[tx_shaper_pkg::CTRL_E1] ?
            r_r.lfsr[tx_shaper_pkg::E1_LEN-1] : r_r.lfsr[tx_shaper_pkg::T1_LEN-1];
      end else if (r_r.ctrl[tx_shaper_pkg::CTRL_DUAL]) begin
         mark = r_r.pos_s2 ^ r_r.neg_s2; // Both rails high is treated as a space
      end else begin
         mark = r_r.pos_s2;
      end
      // Single rail alternates polarity; forced whenever a pattern runs
      if (r_r.ctrl[tx_shaper_pkg::CTRL_DUAL] && !diag) begin
         mark_pol = r_r.neg_s2;
      end else begin
         mark_pol = ~r_r.ami_last;
      end

      // Pattern register steps once per bit, zero state reseeds
      if (bit_go && r_r.ctrl[tx_shaper_pkg::CTRL_QRSS] && !r_r.clk_lost) begin
         lfsr_n = {r_r.lfsr[18:0], fb};
         if (r_r.ctrl[tx_shaper_pkg::CTRL_E1]) begin
            lfsr_n[19:15] = 5'h00;
         end
         if (lfsr_n == 20'h00000) begin
            lfsr_n = tx_shaper_pkg::LFSR_RST;
         end
      end
      r_nxt.lfsr = lfsr_n;

      // Start a pulse and run the monitor once per bit
      if (bit_go) begin
         if (mark) begin
            r_nxt.seg_act  = 1'b1;
            r_nxt.seg_idx  = 3'h0;
            r_nxt.seg_div  = seg_len;
            r_nxt.pol      = mark_pol;
            r_nxt.ami_last = mark_pol;
            r_nxt.dmo_cnt  = 8'h00;
         end else if (r_r.dmo_cnt <= 8'(tx_shaper_pkg::DMO_LIMIT)) begin
            r_nxt.dmo_cnt = r_r.dmo_cnt + 8'h01;
         end
      end
      r_nxt.dmo_flag = (r_nxt.dmo_cnt > 8'(tx_shaper_pkg::DMO_LIMIT));

      // Segment word: programmed or preset; bad codes give a flat line
      row = r_r.ctrl[tx_shaper_pkg::CTRL_BOS +: 5] - tx_shaper_pkg::BOS_FIRST;
      if (r_r.ctrl[tx_shaper_pkg::CTRL_ARB]) begin
         word = r_r.seg_word[r_r.seg_idx];
      end else if (r_r.ctrl[tx_shaper_pkg::CTRL_BOS +: 5] >= tx_shaper_pkg::BOS_FIRST &&
                   r_r.ctrl[tx_shaper_pkg::CTRL_BOS +: 5] <= tx_shaper_pkg::BOS_LAST) begin
         word = tx_shaper_pkg::PRESET[row[2:0]][r_r.seg_idx];
      end

      // Negative pulse flips the sign of every segment
      if (r_r.seg_act) begin
         r_nxt.dac = {word[6] ^ r_r.pol, word[5:0]};
      end else begin
         r_nxt.dac = 7'h00;
      end
      r_nxt.at_rail = (r_nxt.dac[5:0] == 6'h3F);
      r_nxt.tip  = r_nxt.dac[5:0] != 6'h00 && !r_nxt.dac[6];
      r_nxt.ring = r_nxt.dac[5:0] != 6'h00 && r_nxt.dac[6];
      r_nxt.oe   = ~r_r.ctrl[tx_shaper_pkg::CTRL_TRI];

      // Data phase write, applied before the read mux sees it
      if (r_r.ph_valid && r_r.ph_write) begin
         if (r_r.ph_addr == tx_shaper_pkg::CTRL_OFS) begin
            r_nxt.ctrl = hwdata[15:0];
         end else if (r_r.ph_addr == tx_shaper_pkg::MASK_OFS) begin
            r_nxt.mask = hwdata[1:0];
         end else if (r_r.ph_addr[7:5] == tx_shaper_pkg::SEG_BLK && r_r.ph_addr[1:0] == 2'h0) begin
            r_nxt.seg_word[r_r.ph_addr[4:2]] = hwdata[6:0];
         end
      end

      // Sticky events; a fresh event outlasts a clearing read
      ev[tx_shaper_pkg::STAT_DMO_EV]  = r_nxt.dmo_flag ^ r_r.dmo_flag;
      ev[tx_shaper_pkg::STAT_LOSS_EV] = r_nxt.clk_lost ^ r_r.clk_lost;

      // Address phase: decode, read mux, read side effects
      addr_ok = hsel & htrans[1] & hready & (haddr[31:8] == 24'h000000);
      r_nxt.ph_valid = addr_ok;
      r_nxt.ph_write = hwrite;
      r_nxt.ph_addr  = haddr[7:0];
      if (addr_ok && !hwrite) begin
         if (haddr[7:0] == tx_shaper_pkg::CTRL_OFS) begin
            rd[15:0] = r_nxt.ctrl;
         end else if (haddr[7:0] == tx_shaper_pkg::STAT_OFS) begin
            rd[1:0] = r_r.status | ev;
            rd[tx_shaper_pkg::STAT_DMO_LIVE] = r_r.dmo_flag;
            rd[tx_shaper_pkg::STAT_LOSS_LIV] = r_r.clk_lost;
            clr = 2'h3;
         end else if (haddr[7:0] == tx_shaper_pkg::MASK_OFS) begin
            rd[1:0] = r_nxt.mask;
         end else if (haddr[7:5] == tx_shaper_pkg::SEG_BLK && haddr[1:0] == 2'h0) begin
            rd[6:0] = r_nxt.seg_word[haddr[4:2]];
         end
      end
      r_nxt.rdata  = rd;
      r_nxt.status = (r_r.status & ~clr) | ev;
      r_nxt.irq_n  = ~|(r_nxt.status & r_nxt.mask);
   end

   // State register; hsize is ignored as only word transfers occur
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_r          <= '0;
         r_r.lfsr     <= tx_shaper_pkg::LFSR_RST;
         r_r.ctrl     <= tx_shaper_pkg::CTRL_RST;
         r_r.mask     <= tx_shaper_pkg::MASK_RST;
         r_r.seg_word <= {8{tx_shaper_pkg::SEG_RST}};
         r_r.rdy      <= 1'b1;
         r_r.oe       <= 1'b1;
         r_r.irq_n    <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Outputs straight from the state register
   assign hreadyout           = r_r.rdy;
   assign hresp               = r_r.resp;
   assign hrdata              = r_r.rdata;
   assign dac_code            = r_r.dac;
   assign dac_at_rail         = r_r.at_rail;
   assign line_out_tip        = r_r.tip;
   assign line_out_ring       = r_r.ring;
   assign line_out_oe         = r_r.oe;
   assign driver_monitor_flag = r_r.dmo_flag;
   assign irq_n               = r_r.irq_n;

endmodule // tx_shaper

// >>> tx_shaper_asserts.sv
// Port-level concurrent checks for the transmit shaper
`timescale 1ns/10ps
module tx_shaper_asserts (
   // Bus side
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Line and monitor side
   input wire logic [6:0]  dac_code,
   input wire logic        dac_at_rail,
   input wire logic        line_out_tip,
   input wire logic        line_out_ring,
   input wire logic        driver_monitor_flag,
   input wire logic        irq_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_ph_r;
   // Marks the data phase of a taken read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rd_ph_r <= 1'b0;
      else rd_ph_r <= hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h000000;
   end
   property p_rail; dac_at_rail == (dac_code[5:0] == 6'h3F); endproperty
   a_rail: assert property (p_rail) else $error("rail flag differs from magnitude");
   property p_rail_drv; dac_at_rail |-> line_out_tip || line_out_ring; endproperty
   a_rail_drv: assert property (p_rail_drv) else $error("rail with idle line");
   property p_tip; line_out_tip |-> !dac_code[6] && dac_code[5:0] != 6'h00; endproperty
   a_tip: assert property (p_tip) else $error("tip without positive segment");
   property p_ring; line_out_ring |-> dac_code[6] && dac_code[5:0] != 6'h00; endproperty
   a_ring: assert property (p_ring) else $error("ring without negative segment");
   property p_flat; dac_code[5:0] == 6'h00 |-> !line_out_tip && !line_out_ring; endproperty
   a_flat: assert property (p_flat) else $error("line driven on zero code");
   // Flag may only rise after a quiet line
   property p_flag_rise;
      $rose(driver_monitor_flag) |-> $past(dac_code, 1) == 7'h00 && $past(dac_code, 2) == 7'h00;
   endproperty
   a_flag_rise: assert property (p_flag_rise) else $error("monitor flag during pulse");
   property p_rdata; !rd_ph_r |-> hrdata == 32'h00000000; endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside data phase");
   property p_rst; $rose(hresetn) |-> irq_n && !driver_monitor_flag && dac_code == 7'h00; endproperty
   a_rst: assert property (p_rst) else $error("outputs not quiet after reset");
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
   c_tip: cover property ($rose(line_out_tip));
   c_ring: cover property ($rose(line_out_ring));
   c_flag: cover property ($rose(driver_monitor_flag));
   c_irq: cover property ($fell(irq_n));
endmodule // tx_shaper_asserts

bind tx_shaper tx_shaper_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .dac_code(dac_code), .dac_at_rail(dac_at_rail),
   .line_out_tip(line_out_tip), .line_out_ring(line_out_ring),
   .driver_monitor_flag(driver_monitor_flag), .irq_n(irq_n));

// >>> line_dac_model.sv
// Behavioural model of the analog line driver DAC
`timescale 1ns/10ps
module line_dac_model (
   // Codes from the shaper
   input wire logic [6:0] dac_code,
   input wire logic       line_out_oe,
   // Signed line level in DAC steps
   output int             level
);
   // Released driver leaves the terminated line flat
   always_comb begin
      if (!line_out_oe) level = 0;
      else if (dac_code[6]) level = -int'(dac_code[5:0]);
      else level = int'(dac_code[5:0]);
   end
endmodule // line_dac_model

// >>> tb_t1e1_transmit_shaper.sv
// Self-checking testbench for the transmit shaper
`timescale 1ns/10ps
module tb_t1e1_transmit_shaper;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic        hready, hreadyout, hresp, lclk = 1'b0, lclk_on = 1'b0;
   logic        txp = 1'b0, txn = 1'b0, tip, ring, oe, flag, irq_n, rail;
   logic [6:0]  dac;
   int          level, s_d = 0, miscompares = 0, num_checks = 0, ctrl_m = 0, mask_m = 0;
   int          seg_m[8], pol_q[$];
   logic [1:0]  bit_q[$];
   assign hready = hreadyout;
   always #20 hclk = ~hclk;
   // Link clock in its own phase, still while disabled
   initial begin
      #7;
      forever #160 lclk = lclk_on ? ~lclk : 1'b0;
   end
   // Rail data changes on the falling link edge
   always @(negedge lclk) {txp, txn} <= (bit_q.size() > 0) ? bit_q.pop_front() : 2'b00;
   // Record the direction of each new line excursion
   always @(negedge hclk) begin
      if (level != 0 && (s_d == 0 || (level > 0) != (s_d > 0))) pol_q.push_back(level > 0);
      s_d = level;
   end
   tx_shaper dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .line_tx_clock(lclk), .tx_data_positive(txp),
      .tx_data_negative(txn), .dac_code(dac), .dac_at_rail(rail), .line_out_tip(tip),
      .line_out_ring(ring), .line_out_oe(oe), .driver_monitor_flag(flag), .irq_n(irq_n));
   line_dac_model u_dac (.dac_code(dac), .line_out_oe(oe), .level(level));
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; waits on hready, no fixed latency assumed
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
      if (a == 32'h0) ctrl_m = d & 32'h1F3F;
      if (a == 32'h8) mask_m = d & 32'h3;
      if (a >= 32'h20 && a <= 32'h3C) seg_m[a[4:2]] = d & 32'h7F;
   endtask
   task automatic chk_rd(input logic [31:0] a);
      logic [31:0] r, e;
      ahb(1'b0, a, 32'h0, r);
      e = a == 32'h0 ? ctrl_m : a == 32'h8 ? mask_m : a >= 32'h20 && a <= 32'h3C ? seg_m[a[4:2]] : 0;
      chk(r, e);
   endtask
   task automatic chk_st(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, 32'h4, 32'h0, r);
      chk(r & m, e);
   endtask
   // Sends one bit and compares the eight segments of its pulse
   task automatic cap(input logic [1:0] b, input int sl, input logic [6:0] w[8]);
      int n;
      n = 0;
      bit_q.push_back(b);
      do @(negedge hclk); while (dac == 7'h00 && n++ < 60);
      foreach (w[k]) begin
         chk(dac, w[k]);
         chk({rail, tip, ring}, {w[k][5:0] == 6'h3F, !w[k][6], w[k][6]});
         repeat (sl) @(negedge hclk);
      end
   endtask
   // Watchdog, well beyond the expected run
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
   initial begin
      logic [6:0] w[8];
      logic [6:0] wn[8];
      logic [31:0] r;
      void'($urandom(79829));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      lclk_on <= 1'b1;
      for (int a = 0; a < 'h44; a += 4) if (a != 4) chk_rd(a);
      wr(32'h40, $urandom());
      chk_rd(32'h40);
      // Random signed words, one at full scale
      foreach (w[k]) begin
         w[k] = k == 3 ? 7'h7F : 7'($urandom_range(63, 1)) | 7'($urandom_range(1, 0) << 6);
         wn[k] = w[k] ^ 7'h40;
         wr(32'h20 + 4 * k, {25'h0, w[k]});
         chk_rd(32'h20 + 4 * k);
      end
      wr(32'h0, 32'h30);
      cap(2'b10, 2, w);
      cap(2'b01, 2, wn);
      for (int i = 0; i < 5; i++) begin
         wr(32'h0, 32'h20 | (32'h8 + i) << 8);
         foreach (wn[k]) wn[k] = tx_shaper_pkg::PRESET[i][k];
         cap(2'b10, 2, wn);
      end
      wr(32'h0, 32'h0720);
      pol_q.delete();
      bit_q.push_back(2'b10);
      repeat (40) @(negedge hclk);
      chk(pol_q.size(), 0);
      wr(32'h0, 32'h38);
      repeat (2) @(negedge hclk);
      chk(oe, 1'b0);
      wr(32'h0, 32'h30);
      repeat (2) @(negedge hclk);
      chk(oe, 1'b1);
      // Pattern over idle rails, both line modes; a reset reseeds it to all ones
      for (int m = 0; m < 2; m++) begin
         @(posedge hclk);
         hresetn <= 1'b0;
         repeat (2) @(posedge hclk);
         hresetn <= 1'b1;
         for (int k = 0; k < 8; k++) wr(32'h20 + 4 * k, 32'h01 + k);
         wr(32'h0, m ? 32'h32 : 32'h33);
         pol_q.delete();
         repeat (12) @(posedge lclk);
         chk(pol_q.size() > 9, 1'b1);
         for (int k = 1; k < pol_q.size(); k++) chk(pol_q[k], !pol_q[k-1]);
      end
      wr(32'h0, 32'h10); // Single rail data, no pattern
      wr(32'h8, 32'h1);
      bit_q.push_back(2'b10);
      repeat (3) @(posedge lclk);
      ahb(1'b0, 32'h4, 32'h0, r);
      repeat (122) @(posedge lclk);
      chk(flag, 1'b0);
      chk(irq_n, 1'b1);
      repeat (10) @(posedge lclk);
      chk(flag, 1'b1);
      chk(irq_n, 1'b0);
      chk_st(32'h101, 32'h101);
      repeat (2) @(negedge hclk);
      chk(irq_n, 1'b1);
      chk_st(32'h1, 32'h0);
      bit_q.push_back(2'b10);
      repeat (4) @(posedge lclk);
      chk(flag, 1'b0);
      chk(irq_n, 1'b0);
      ahb(1'b0, 32'h4, 32'h0, r);
      wr(32'h8, 32'h0);
      // Stopped link clock with each fill choice
      wr(32'h0, 32'h35);
      lclk_on <= 1'b0;
      repeat (100) @(posedge hclk);
      pol_q.delete();
      repeat (160) @(posedge hclk);
      chk(pol_q.size() >= 8, 1'b1);
      chk_st(32'h200, 32'h200);
      wr(32'h0, 32'h31);
      repeat (20) @(posedge hclk);
      pol_q.delete();
      repeat (100) @(posedge hclk);
      chk(pol_q.size(), 0);
      lclk_on <= 1'b1;
      complete_run();
   end
endmodule // tb_t1e1_transmit_shaper
